/* File: smi_pkg.sv */
// shared constants, carrier structs and state codes for the serial master
// assumes a single clock domain; pins arrive unsynchronised
package smi_pkg;
  // ----------------------------------------------------------------
  // widths and depths
  // ----------------------------------------------------------------
  localparam int unsigned SMI_BITS = 8;
  localparam int unsigned SMI_FIFO_DEPTH = 4;
  localparam logic [3:0] SMI_EDGE_LAST = 4'hf;     // sixteen clock edges per byte
  localparam logic [7:0] SMI_DATA_RST = 8'h00;
  // ----------------------------------------------------------------
  // shift clock dividers per rate code
  // ----------------------------------------------------------------
  localparam logic [8:0] SMI_DIV_00 = 9'h008;
  localparam logic [8:0] SMI_DIV_01 = 9'h010;
  localparam logic [8:0] SMI_DIV_10 = 9'h080;
  localparam logic [8:0] SMI_DIV_11 = 9'h100;
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic port_enable;
    logic bus_mode_select;
    logic clock_idle_polarity;
    logic clock_capture_phase;
    logic rate_select_hi;
    logic rate_select_lo;
  } smi_ctrl_s;
  typedef struct packed {
    logic busy;
    logic arbitration_lost_flag;
  } smi_status_s;
  typedef enum logic [1:0] {
    SMI_IDLE = 2'b01,
    SMI_SHIFT = 2'b10
  } smi_state_e;
  // half a shift clock period in internal clock cycles
  function automatic logic [7:0] smi_half_count(input logic hi, input logic lo);
    logic [8:0] div;
    div = SMI_DIV_00;
    case ({hi, lo})
      2'b00: div = SMI_DIV_00;
      2'b01: div = SMI_DIV_01;
      2'b10: div = SMI_DIV_10;
      default: div = SMI_DIV_11;
    endcase
    return 8'(div >> 1);
  endfunction : smi_half_count
endpackage : smi_pkg

/* File: smi_fifo.sv */
// small synchronous fifo for bytes waiting to be shifted out
// assumes writer and reader share i_clock
module smi_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input wire logic i_clock,               // internal clock
  input wire logic i_rst_b,               // async reset, active low
  input wire logic i_in_valid,            // writer offers a word
  input wire logic [WIDTH-1:0] i_in_data, // word offered
  output logic o_in_ready,                // room for a word, registered
  output logic o_out_valid,               // a word is waiting
  output logic [WIDTH-1:0] o_out_data,    // oldest word
  input wire logic i_out_ready            // reader takes the word
);
  import smi_pkg::*;
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic rdy_r, rdy_nxt;
  logic push, pop;

  // ----------------------------------------------------------------
  // pointer and level update
  // ----------------------------------------------------------------
  // ready is registered so the top port comes from a flop; it costs nothing
  // since it is recomputed from the next level
  always_comb begin
    push = i_in_valid & rdy_r;
    pop = i_out_ready & (cnt_r != '0);
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    if (push) begin
      wp_nxt = (wp_r == AW'(DEPTH - 1)) ? '0 : AW'(wp_r + 1'b1);
    end
    if (pop) begin
      rp_nxt = (rp_r == AW'(DEPTH - 1)) ? '0 : AW'(rp_r + 1'b1);
    end
    cnt_nxt = CW'(cnt_r + CW'(push) - CW'(pop));
    rdy_nxt = (cnt_nxt != CW'(DEPTH));
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      rdy_r <= 1'b0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  // storage needs no reset; reads are gated by the level
  always_ff @(posedge i_clock) begin
    if (push) begin
      mem_r[wp_r] <= i_in_data;
    end
  end

  assign o_in_ready = rdy_r;
  assign o_out_valid = (cnt_r != '0);
  assign o_out_data = mem_r[rp_r];
endmodule : smi_fifo

/* File: smi_spi_master.sv */
// master-only serial shift port with two-wire bus assist
// assumes pins are asynchronous to i_clock; pad logic resolves the wires
module smi_spi_master (
  input wire logic i_clock,                         // internal clock, 10 MHz
  input wire logic i_rst_b,                         // async reset, active low
  input wire smi_pkg::smi_ctrl_s i_ctrl,            // control bits
  input wire logic i_arb_clear,                     // software clears lost flag
  input wire logic i_wr_valid,                      // new data byte offered
  input wire logic [smi_pkg::SMI_BITS-1:0] i_wr_data, // data byte to send
  output logic o_wr_ready,                          // byte buffer has room
  output logic [smi_pkg::SMI_BITS-1:0] o_rx_data,   // last received byte
  output logic o_rx_valid,                          // one-cycle pulse, byte done
  output smi_pkg::smi_status_s o_status,            // busy and lost flag
  output logic o_irq,                               // shared interrupt channel
  input wire logic i_sck,                           // shift clock pin level
  output logic o_sck_out,                           // shift clock drive value
  output logic o_sck_oe,                            // shift clock drive enable
  input wire logic i_sdi,                           // serial_in pin level
  output logic o_sdo_out,                           // serial_out drive value
  output logic o_sdo_oe                             // serial_out drive enable
);
  import smi_pkg::*;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  // ----------------------------------------------------------------
  // pin synchronisers and spike filters
  // ----------------------------------------------------------------
  logic sck_m_r, sck_s_r, sck_p_r, sck_f_r, sck_d_r, sck_f_nxt;
  logic sdi_m_r, sdi_s_r, sdi_p_r, sdi_f_r, sdi_d_r, sdi_f_nxt;

  // a level is accepted only after two equal samples, so a one-cycle spike never passes
  always_comb begin
    sck_f_nxt = (sck_s_r == sck_p_r) ? sck_s_r : sck_f_r;
    sdi_f_nxt = (sdi_s_r == sdi_p_r) ? sdi_s_r : sdi_f_r;
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      {sck_m_r, sck_s_r, sck_p_r, sck_f_r, sck_d_r} <= 5'h00;
      {sdi_m_r, sdi_s_r, sdi_p_r, sdi_f_r, sdi_d_r} <= 5'h1f;
    end else begin
      {sck_m_r, sck_s_r, sck_p_r} <= {i_sck, sck_m_r, sck_s_r};
      {sdi_m_r, sdi_s_r, sdi_p_r} <= {i_sdi, sdi_m_r, sdi_s_r};
      {sck_f_r, sck_d_r} <= {sck_f_nxt, sck_f_r};
      {sdi_f_r, sdi_d_r} <= {sdi_f_nxt, sdi_f_r};
    end
  end

  filter_hold_a: assert property ($changed(sck_f_r) |-> $past(sck_s_r) == $past(sck_p_r))
    else $error("clock filter passed a single-sample spike");

  // ----------------------------------------------------------------
  // byte buffer in front of the shift register
  // ----------------------------------------------------------------
  logic fifo_valid, core_ready;
  logic [SMI_BITS-1:0] fifo_data;

  smi_fifo #(.WIDTH(SMI_BITS), .DEPTH(SMI_FIFO_DEPTH)) u_fifo (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_in_valid(i_wr_valid),
    .i_in_data(i_wr_data),
    .o_in_ready(o_wr_ready),
    .o_out_valid(fifo_valid),
    .o_out_data(fifo_data),
    .i_out_ready(core_ready)
  );

  // ----------------------------------------------------------------
  // shift engine
  // ----------------------------------------------------------------
  smi_state_e state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt, half;
  logic [3:0] edge_r, edge_nxt;
  logic [SMI_BITS-1:0] sh_r, sh_nxt, sh_cap, rx_r, rx_nxt;
  logic sck_r, sck_nxt, sdo_r, sdo_nxt, arb_r, arb_nxt, busy_r, busy_nxt;
  logic rxv_r, rxv_nxt, bms_d_r, irq_r, irq_nxt;
  logic bus, bms_fall, hold, tick, edge_evt, cap, shout, load, done, arb_set, ss_evt, eot, sdi_cap;

  always_comb begin
    bus = i_ctrl.bus_mode_select;
    bms_fall = bms_d_r & ~bus;
    half = smi_half_count(i_ctrl.rate_select_hi, i_ctrl.rate_select_lo);
    // a released clock that another master still pulls low freezes the count
    hold = bus & sck_r & ~sck_f_r;
    tick = (state_r == SMI_SHIFT) & ~hold & (cnt_r == half - 8'h01);
    // in bus mode the line itself clocks the shifter, so a slower master sets the pace
    edge_evt = (state_r == SMI_SHIFT) & (bus ? (sck_f_r != sck_d_r) : tick);
    cap = edge_evt & (edge_r[0] == i_ctrl.clock_capture_phase);
    // the first edge with late capture only confirms the bit already on the pin
    shout = edge_evt & ~cap & (edge_r != 4'h0);
    done = edge_evt & (edge_r == SMI_EDGE_LAST);
    load = core_ready & fifo_valid;
    arb_set = cap & bus & sdo_r & ~sdi_f_r;
    eot = done | bms_fall;
    ss_evt = bus & sck_f_r & sck_d_r & (sdi_f_r != sdi_d_r);
    // spi mode takes data straight from the synchroniser: the filter's extra delay would miss a
    // slave's trailing-edge bit at the fastest rate; bus mode keeps the filtered line to match its clock
    sdi_cap = bus ? sdi_f_r : sdi_s_r;
    sh_cap = cap ? {sh_r[SMI_BITS-2:0], sdi_cap} : sh_r;
  end

  // the buffer drains only into an idle, enabled shifter
  assign core_ready = (state_r == SMI_IDLE) & i_ctrl.port_enable & ~bms_fall;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    edge_nxt = edge_r;
    sh_nxt = sh_cap;
    sck_nxt = sck_r;
    sdo_nxt = sdo_r;
    busy_nxt = busy_r;
    rx_nxt = rx_r;
    rxv_nxt = 1'b0;
    // set wins over a software clear arriving in the same cycle
    arb_nxt = arb_set ? 1'b1 : ((load | i_arb_clear) ? 1'b0 : arb_r);
    case (state_r)
      SMI_IDLE: begin
        sck_nxt = i_ctrl.clock_idle_polarity;
        cnt_nxt = 8'h00;
        edge_nxt = 4'h0;
        if (load) begin
          state_nxt = SMI_SHIFT;
          sh_nxt = fifo_data;
          sdo_nxt = fifo_data[SMI_BITS-1];
          busy_nxt = 1'b1;
        end
      end
      SMI_SHIFT: begin
        if (!hold) begin
          cnt_nxt = tick ? 8'h00 : (cnt_r + 8'h01);
        end
        if (tick) begin
          sck_nxt = ~sck_r;
        end
        if (edge_evt) begin
          edge_nxt = edge_r + 4'h1;
        end
        if (shout) begin
          sdo_nxt = sh_r[SMI_BITS-1];
        end
        if (done) begin
          state_nxt = SMI_IDLE;
          busy_nxt = 1'b0;
          rx_nxt = sh_cap;
          rxv_nxt = 1'b1;
          sck_nxt = i_ctrl.clock_idle_polarity;
        end
        if (bms_fall) begin
          state_nxt = SMI_IDLE;
          busy_nxt = 1'b0;
          sck_nxt = i_ctrl.clock_idle_polarity;
        end
      end
      default: begin
        state_nxt = SMI_IDLE;
        busy_nxt = 1'b0;
      end
    endcase
    // shared channel: pin level, start/stop pulse, or end-of-byte or bus-mode-exit pulse
    case ({i_ctrl.port_enable, bus})
      2'b00: irq_nxt = sck_f_r;
      2'b01: irq_nxt = ss_evt;
      default: irq_nxt = eot;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= SMI_IDLE;
      cnt_r <= 8'h00;
      edge_r <= 4'h0;
      sh_r <= SMI_DATA_RST;
      rx_r <= SMI_DATA_RST;
      rxv_r <= 1'b0;
      sck_r <= 1'b0;
      sdo_r <= 1'b1;
      arb_r <= 1'b0;
      busy_r <= 1'b0;
      bms_d_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      edge_r <= edge_nxt;
      sh_r <= sh_nxt;
      rx_r <= rx_nxt;
      rxv_r <= rxv_nxt;
      sck_r <= sck_nxt;
      sdo_r <= sdo_nxt;
      arb_r <= arb_nxt;
      busy_r <= busy_nxt;
      bms_d_r <= bus;
      irq_r <= irq_nxt;
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  logic sck_o_r, sck_oe_r, sdo_o_r, sdo_oe_r, sck_oe_nxt, sdo_oe_nxt;

  // bus mode drives only low so the wire stays open drain; lost arbitration leaves the line high
  always_comb begin
    sck_oe_nxt = i_ctrl.port_enable & (~bus | ~sck_r);
    sdo_oe_nxt = i_ctrl.port_enable & ~arb_r & (~bus | ~sdo_r);
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      {sck_o_r, sck_oe_r, sdo_o_r, sdo_oe_r} <= 4'h2;
    end else begin
      {sck_o_r, sck_oe_r} <= {sck_r, sck_oe_nxt};
      {sdo_o_r, sdo_oe_r} <= {sdo_r | arb_r, sdo_oe_nxt};
    end
  end

  assign o_sck_out = sck_o_r;
  assign o_sck_oe = sck_oe_r;
  assign o_sdo_out = sdo_o_r;
  assign o_sdo_oe = sdo_oe_r;
  assign o_rx_data = rx_r;
  assign o_rx_valid = rxv_r;
  assign o_irq = irq_r;
  assign o_status = '{busy: busy_r, arbitration_lost_flag: arb_r};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_load;
    load;
  endsequence
  sequence s_lost;
    arb_set;
  endsequence

  disabled_pins_a: assert property (!i_ctrl.port_enable [*2] |-> !o_sck_oe && !o_sdo_oe)
    else $error("pins driven while port disabled");
  msb_first_a: assert property (s_load |=> sdo_r == $past(fifo_data[SMI_BITS-1]) && busy_r)
    else $error("first bit is not the msb");
  arb_lost_a: assert property (s_lost |=> arb_r ##1 !o_sdo_oe)
    else $error("lost arbitration did not drop driver");
  arb_clear_a: assert property (s_load and !arb_set |=> !arb_r)
    else $error("data write did not clear lost flag");
  busy_end_a: assert property (done && !bms_fall |=> !busy_r && o_rx_valid && o_rx_data == $past(sh_cap))
    else $error("byte end did not clear busy");
  abort_a: assert property (bms_fall && i_ctrl.port_enable |=> state_r == SMI_IDLE && o_irq)
    else $error("bus mode clear did not abort with irq");
  rate_gap_a: assert property (tick && !bus |=> !tick [*3])
    else $error("shift clock half period too short");
  start_stop_irq_a: assert property (ss_evt && !i_ctrl.port_enable |=> o_irq)
    else $error("start or stop did not reach channel");
  clock_hold_a: assert property (hold && state_r == SMI_SHIFT |=> cnt_r == $past(cnt_r))
    else $error("counting ran while line held low");

  // ----------------------------------------------------------------
  // clock level, channel, pulse and lost flag checks
  // ----------------------------------------------------------------
  // idle level tracks polarity even while disabled, so enabling never glitches the line
  idle_level_a: assert property (state_r == SMI_IDLE |=> sck_r == $past(i_ctrl.clock_idle_polarity))
    else $error("idle clock level differs from polarity");
  // the shared channel must carry the chosen source one cycle later
  pin_irq_a: assert property (!i_ctrl.port_enable && !bus |=> o_irq == $past(sck_f_r))
    else $error("shared channel does not follow the pin");
  end_irq_a: assert property (done && i_ctrl.port_enable |=> o_irq)
    else $error("byte end did not reach channel");
  // a high clock in bus mode is only ever a release, never a drive
  bus_release_a: assert property (bus && sck_r |=> !o_sck_oe)
    else $error("clock driven high in bus mode");
  rx_pulse_a: assert property (o_rx_valid |=> !o_rx_valid)
    else $error("byte done pulse lasted too long");
  arb_hold_a: assert property (arb_r && !load && !i_arb_clear |=> arb_r)
    else $error("lost flag dropped without a clear");
endmodule : smi_spi_master

/* File: smi_slave_model.sv */
// far-side model: a plain shift slave on the serial master's clock and data lines
// assumes the bench resolves pin levels and pulses i_sync before the first frame of each run
module smi_slave_model (
  input wire logic i_sck,          // resolved clock line
  input wire logic i_mosi,         // resolved serial_out line
  input wire logic i_clock_idle_polarity,         // idle clock level
  input wire logic i_clock_capture_phase,         // capture on second edge when high
  input wire logic i_sync,         // rising edge starts a new frame
  input wire logic [7:0] i_reply,  // byte returned to the master
  output logic o_miso,             // serial_in drive value
  output logic [7:0] o_got         // last byte received
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] tx;
  logic [7:0] rx;
  int edges;
  // idle until the bench arms a frame, so enable glitches are not counted
  initial begin
    tx = 8'h00;
    rx = 8'h00;
    edges = 16;
    o_miso = 1'b1;
    o_got = 8'h00;
  end
  // ------------------------------------------------------------------
  // framing and shifting
  // ------------------------------------------------------------------
  // arm a frame; with capture on the first edge the msb must already stand
  always @(posedge i_sync) begin
    tx = i_reply;
    rx = 8'h00;
    edges = 0;
    if (!i_clock_capture_phase) begin
      o_miso = tx[7];
    end
  end
  // two edges a bit; only eight data bits, acknowledge is left to software
  always @(i_sck) begin
    if (edges < 16) begin
      if (i_sck !== i_clock_idle_polarity) begin
        if (i_clock_capture_phase) begin
          o_miso = tx[7];
          tx = tx << 1;
        end else begin
          rx = {rx[6:0], i_mosi};
        end
      end else begin
        if (i_clock_capture_phase) begin
          rx = {rx[6:0], i_mosi};
        end else begin
          tx = tx << 1;
          o_miso = tx[7];
        end
      end
      edges++;
      // re-arm at once so back-to-back bytes keep their framing
      if (edges == 16) begin
        o_got = rx;
        tx = i_reply;
        edges = 0;
        if (!i_clock_capture_phase) begin
          o_miso = tx[7];
        end
      end
    end
  end
endmodule : smi_slave_model

/* File: testbench.sv */
// self-checking bench for the serial master with two-wire assist
// assumes smi_pkg, smi_fifo, smi_spi_master and smi_slave_model are compiled first
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import smi_pkg::*;
  logic i_clock, i_rst_b, arb_clear, wr_valid, wr_ready, rx_valid, irq, sync, ext_sck, hold_scl, pull_sda;
  logic sck_out, sck_oe, sdo_out, sdo_oe, sck_line, sdi_line, mosi, miso;
  logic [7:0] wr_data, rx_data, reply, got;
  smi_ctrl_s ctrl;
  smi_status_s status;
  int errors, cmp_count, irq_cnt, busy_cnt, sdo_cnt, oe_cnt, rx_cnt;
  int divs[4] = '{8, 16, 128, 256};
  // ------------------------------------------------------------------
  // wiring, clock and monitors
  // ------------------------------------------------------------------
  // open-drain data line in bus mode, push-pull otherwise
  assign sck_line = hold_scl ? 1'b0 : (sck_oe ? sck_out : ext_sck);
  assign mosi = sdo_oe ? sdo_out : 1'bz;
  assign sdi_line = ctrl.bus_mode_select ? ~((sdo_oe & ~sdo_out) | pull_sda) : miso;
  smi_spi_master smi_spi_master_i (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_ctrl(ctrl), .i_arb_clear(arb_clear),
    .i_wr_valid(wr_valid), .i_wr_data(wr_data), .o_wr_ready(wr_ready), .o_rx_data(rx_data), .o_rx_valid(rx_valid),
    .o_status(status), .o_irq(irq), .i_sck(sck_line), .o_sck_out(sck_out), .o_sck_oe(sck_oe), .i_sdi(sdi_line),
    .o_sdo_out(sdo_out), .o_sdo_oe(sdo_oe));
  smi_slave_model smi_slave_model_i (.i_sck(sck_line), .i_mosi(mosi), .i_clock_idle_polarity(ctrl.clock_idle_polarity),
    .i_clock_capture_phase(ctrl.clock_capture_phase), .i_sync(sync), .i_reply(reply), .o_miso(miso), .o_got(got));
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end
  // counted on the falling edge so outputs have settled and clears never race
  always @(negedge i_clock) begin
    irq_cnt += (irq === 1'b1);
    busy_cnt += (status.busy === 1'b1);
    sdo_cnt += (sdo_oe === 1'b1);
    oe_cnt += (sdo_oe === 1'b1 || sck_oe === 1'b1);
    rx_cnt += (rx_valid === 1'b1);
  end
  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic watch(input int n);
    irq_cnt = 0;
    busy_cnt = 0;
    sdo_cnt = 0;
    oe_cnt = 0;
    rx_cnt = 0;
    repeat (n) @(posedge i_clock);
  endtask : watch
  // offer one byte and keep valid up; the caller drops it after the last byte
  task automatic put(input logic [7:0] b);
    int n;
    n = 0;
    wr_valid <= 1'b1;
    wr_data <= b;
    do begin
      @(posedge i_clock);
      n++;
    end while (wr_ready !== 1'b1 && n < 200);
    check("write taken", wr_ready, 1'b1);
  endtask : put
  // one framed byte; counters run from the frame's start to just after its end
  task automatic xfer(input logic [7:0] tx, input logic [7:0] rep);
    int n;
    n = 0;
    reply <= rep;
    sync <= 1'b1;
    watch(1);
    sync <= 1'b0;
    put(tx);
    wr_valid <= 1'b0;
    do begin
      @(posedge i_clock);
      n++;
    end while (rx_valid !== 1'b1 && n < 5000);
    check("byte done", rx_valid, 1'b1);
    repeat (3) @(posedge i_clock);
  endtask : xfer
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  // longest run is a few thousand cycles; this is far beyond it
  initial begin
    repeat (60000) @(posedge i_clock);
    errors++;
    $display("unexpected watchdog: expected finish seen hang");
    report_and_stop();
  end
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  initial begin
    i_rst_b = 1'b0;
    ctrl = '0;
    arb_clear = 1'b0;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    sync = 1'b0;
    ext_sck = 1'b0;
    hold_scl = 1'b0;
    pull_sda = 1'b0;
    reply = 8'h00;
    errors = 0;
    cmp_count = 0;
    repeat (4) @(posedge i_clock);
    check("reset status", status, 2'b00);
    i_rst_b <= 1'b1;
    // disabled port: pins released, shared channel follows the clock pin, spikes ignored
    watch(3);
    ext_sck <= #20 1'b1;
    ext_sck <= #110 1'b0;
    watch(12);
    check("irq on spike", irq_cnt, 0);
    ext_sck <= 1'b1;
    watch(12);
    check("irq follows pin", irq, 1'b1);
    ext_sck <= 1'b0;
    watch(12);
    check("irq pin low", irq, 1'b0);
    check("pins driven", oe_cnt, 0);
    // start and stop only count while the clock line is high
    ctrl <= smi_ctrl_s'(6'b010000);
    ext_sck <= 1'b1;
    watch(12);
    pull_sda <= 1'b1;
    watch(12);
    check("start irq", irq_cnt, 1);
    pull_sda <= 1'b0;
    watch(12);
    check("stop irq", irq_cnt, 1);
    ext_sck <= 1'b0;
    watch(12);
    pull_sda <= 1'b1;
    watch(12);
    check("irq fall clock low", irq_cnt, 0);
    pull_sda <= 1'b0;
    watch(12);
    check("irq clock low", irq_cnt, 0);
    // every polarity and phase, full duplex exchange
    for (int m = 0; m < 4; m++) begin
      ctrl <= smi_ctrl_s'({2'b00, m[1], m[0], 2'b01});
      ext_sck <= m[1]; // clock pin rests at its idle level first
      watch(4);
      ctrl <= smi_ctrl_s'({2'b10, m[1], m[0], 2'b01}); // source switch is not counted
      watch(4); // wait four cycles after the toggle before the idle clock check
      check("idle clock", sck_out, m[1]);
      xfer(8'hb4 ^ 8'(m), 8'h5a + 8'(m));
      check("slave byte", got, 8'hb4 ^ 8'(m));
      check("rx byte", rx_data, 8'h5a + 8'(m));
      check("end irq", irq_cnt, 1);
      check("clock back idle", sck_out, m[1]);
    end
    // each rate code: busy lasts sixteen half periods of the divided clock
    ext_sck <= 1'b0;
    for (int r = 0; r < 4; r++) begin
      ctrl <= smi_ctrl_s'({4'b1000, r[1], r[0]});
      watch(4);
      xfer(8'hc3, 8'h3c);
      check("busy cycles", busy_cnt, 16'(8 * divs[r]));
      check("busy after", status.busy, 1'b0);
      check("rate rx byte", rx_data, 8'h3c);
      check("rate slave byte", got, 8'hc3);
    end
    // buffer fills while disabled, refuses a fifth byte, then drains back to back
    ctrl <= smi_ctrl_s'(6'b000001);
    watch(4);
    reply <= 8'h99;
    sync <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      put(8'h11 + 8'(k));
    end
    sync <= 1'b0;
    wr_data <= 8'hee;
    watch(10);
    check("buffer full", wr_ready, 1'b0);
    wr_valid <= 1'b0;
    ctrl <= smi_ctrl_s'(6'b100001);
    watch(900);
    check("bytes done", rx_cnt, 4);
    check("end irqs", irq_cnt, 4);
    check("last byte out", got, 8'h14);
    check("buffer room", wr_ready, 1'b1);
    // bus mode: lost arbitration, stretched clock, abort by leaving bus mode
    ctrl <= smi_ctrl_s'(6'b110000);
    ext_sck <= 1'b1;
    pull_sda <= 1'b1;
    watch(8);
    put(8'h80);
    wr_valid <= 1'b0;
    watch(40);
    check("arb lost", status.arbitration_lost_flag, 1'b1);
    hold_scl <= 1'b1;
    watch(100);
    check("held busy", status.busy, 1'b1);
    check("sdo after arb", sdo_cnt, 0);
    ctrl <= smi_ctrl_s'(6'b100000);
    watch(8);
    check("abort busy", status.busy, 1'b0);
    check("abort irq", irq_cnt, 1);
    hold_scl <= 1'b0;
    pull_sda <= 1'b0;
    ctrl <= smi_ctrl_s'(6'b110000);
    watch(8);
    xfer(8'h00, 8'h00);
    check("arb cleared", status.arbitration_lost_flag, 1'b0);
    check("sdo restored", sdo_cnt > 0, 1'b1);
    check("bus rx byte", rx_data, 8'h00);
    report_and_stop();
  end
endmodule : testbench
